// ### design/dimcal_pkg.sv
// constants, register map and types of the dimming and calibration controller
// Function
// - outside limp-home the current target follows the eight-bit software dimming level
// - limp-home is active while the limp-home input is high
// - switching needs both PWM input and enable input high, limp-home included
// - in limp-home the dimming level comes from the level-setting pin
// - outside limp-home the level-setting pin is ignored entirely
// - in limp-home, pin below stop level stops switching, zero current
// - gate drivers on while PWM input high, off while low
// - with PWM low the mode readback keeps the last mode seen while high
// - start written high with calibration enabled runs the offset routine
// - done flag set when the routine ends, about 200 us later
// - calibration enabled: routine result applied and read back as calibration value
// - calibration disabled: software value applied and read back, start refused
// - gate drivers off on external gate supply undervoltage, and on internal undervoltage outside limp-home
// - in limp-home, internal gate supply undervoltage does not affect switching
`default_nettype none
package dimcal_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_ANALOG_DIM = 8'h00;
   localparam logic [7:0] OFF_DEV_CTRL = 8'h04;
   localparam logic [7:0] OFF_CUR_CAL = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0C;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
   // field positions
   localparam int CAL_EN_BIT = 0;
   localparam int CAL_START_BIT = 0;
   localparam int CAL_DONE_BIT = 1;
   localparam int CAL_BUSY_BIT = 2;
   localparam int CAL_VAL_LSB = 8;
   localparam int ST_SWITCH_BIT = 0;
   localparam int ST_GATE_BIT = 1;
   localparam int ST_LIMP_BIT = 2;
   localparam int ST_MODE_LSB = 4;
   localparam int EV_CAL_DONE = 0;
   localparam int EV_GATE_UV = 1;
   localparam int EV_LIMP = 2;
   localparam int NUM_EV = 3;
   // reset values
   localparam logic [7:0] RST_DIM_LEVEL = 8'hFF;
   localparam logic [7:0] RST_CAL_VALUE = 8'h00;
   localparam logic [NUM_EV-1:0] RST_IRQ_MASK = 3'h0;
   localparam logic [1:0] RST_MODE = 2'h0;
   // avalon response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // calibration routine duration
   localparam int CLK_MHZ = 250;
   localparam int CAL_TIME_US = 200;
   localparam int CAL_CYCLES_DEF = CAL_TIME_US * CLK_MHZ;
   localparam int CAL_CNT_W = 16;

   typedef enum logic [0:0] {ENG_IDLE, ENG_RUN} eng_state_t;
endpackage
`default_nettype wire

// ### design/cal_if.sv
// handshake between the register front end and the calibration engine
`default_nettype none
interface cal_if;
   logic start;
   logic busy;
   logic done;
   logic [7:0] result;
   modport ctrl (output start, input busy, input done, input result);
   modport eng (input start, output busy, output done, output result);
endinterface
`default_nettype wire

// ### design/cal_engine.sv
// offset calibration routine: timed run that captures the measured offset
`default_nettype none
module cal_engine
   import dimcal_pkg::*;
#(
   parameter int unsigned CAL_CYCLES = CAL_CYCLES_DEF
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] meas,
   cal_if.eng cal
);
   typedef struct packed {
      eng_state_t st;
      logic [CAL_CNT_W-1:0] cnt;
      logic done;
      logic [7:0] result;
   } eng_t;

   eng_t cur;
   eng_t nxt;
   localparam logic [CAL_CNT_W-1:0] LAST = CAL_CNT_W'(CAL_CYCLES - 1);

   // run the routine for the full duration, then latch the offset
   always_comb begin
      nxt = cur;
      nxt.done = 1'b0;
      case (cur.st)
         ENG_IDLE: begin
            if (cal.start) begin
               nxt.st = ENG_RUN;
               nxt.cnt = '0;
            end
         end
         ENG_RUN: begin
            if (cur.cnt == LAST) begin
               nxt.st = ENG_IDLE;
               nxt.done = 1'b1;
               nxt.result = meas;
            end else begin
               nxt.cnt = cur.cnt + 1'b1;
            end
         end
         default: nxt.st = ENG_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cur <= '{ENG_IDLE, '0, 1'b0, RST_CAL_VALUE};
      end else begin
         cur <= nxt;
      end
   end

   assign cal.busy = (cur.st == ENG_RUN);
   assign cal.done = cur.done;
   assign cal.result = cur.result;
endmodule
`default_nettype wire

// ### design/led_dimming_calibration_ctrl.sv
// analog dimming, limp-home, switching gate and calibration control with avalon registers
//
// The implementer's own choices: register access over Avalon-MM and the register addresses.
`default_nettype none
module led_dimming_calibration_ctrl
   import dimcal_pkg::*;
#(
   parameter int unsigned CAL_CYCLES = CAL_CYCLES_DEF
) (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic [7:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic [1:0] AVS_RESPONSE,
   output logic AVS_WAITREQUEST,
   input wire logic PWM_DIM_IN,
   input wire logic LIMP_HOME_IN,
   input wire logic ENABLE_UV_IN,
   input wire logic GATE_SUPPLY_INT_UV,
   input wire logic GATE_SUPPLY_EXT_UV,
   input wire logic [7:0] SET_PIN_LEVEL,
   input wire logic SET_PIN_BELOW_STOP,
   input wire logic [1:0] REG_MODE_IN,
   input wire logic [7:0] CAL_OFFSET_MEAS,
   output logic [7:0] DIM_TARGET,
   output logic [7:0] CAL_APPLIED,
   output logic SWITCH_EN,
   output logic GATE_DRV_EN,
   output logic IRQ
);
   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic [1:0] resp;
      logic [7:0] dim_level;
      logic cal_enable;
      logic [7:0] sw_cal;
      logic cal_done_flag;
      logic [NUM_EV-1:0] irq_status;
      logic [NUM_EV-1:0] irq_mask;
      logic [1:0] mode_hold;
      logic limp_prev;
      logic uv_prev;
      logic [7:0] dim_target;
      logic [7:0] cal_applied;
      logic switch_en;
      logic gate_en;
   } ctrl_t;

   ctrl_t cur;
   ctrl_t next_cur;
   logic [1:0] rst_sync;
   logic rst_n;
   cal_if cal ();

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
      hit = (addr == off);
   endfunction

   function automatic logic mapped(input logic [7:0] addr);
      mapped = hit(addr, OFF_ANALOG_DIM) | hit(addr, OFF_DEV_CTRL) | hit(addr, OFF_CUR_CAL)
         | hit(addr, OFF_STATUS) | hit(addr, OFF_IRQ_STATUS) | hit(addr, OFF_IRQ_MASK);
   endfunction

   // reset release through two flops, assertion stays asynchronous
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   cal_engine #(
      .CAL_CYCLES(CAL_CYCLES)
   ) u_engine (
      .clk(CLK),
      .rst_n(rst_n),
      .meas(CAL_OFFSET_MEAS),
      .cal(cal.eng)
   );

   logic req;
   logic wr_go;
   logic rd_go;
   logic limp;
   logic uv_block;
   logic gate_on;
   logic sw_on;
   logic start_ok;
   logic [NUM_EV-1:0] events;
   logic [NUM_EV-1:0] irq_next;
   logic [31:0] rd_val;
   logic clr_rd;

   // bus strobe is accepted on the second cycle of each request
   assign req = AVS_READ | AVS_WRITE;
   assign wr_go = AVS_WRITE & cur.ack;
   assign rd_go = AVS_READ & cur.ack;
   // answer edge of a read of the sticky status
   assign clr_rd = rd_go & hit(AVS_ADDRESS, OFF_IRQ_STATUS);

   // switching permission from the pins
   assign limp = LIMP_HOME_IN;
   // internal supply monitor is masked in limp-home
   assign uv_block = GATE_SUPPLY_EXT_UV | (GATE_SUPPLY_INT_UV & ~limp);
   assign gate_on = PWM_DIM_IN & ~uv_block;
   // stop level on the set pin only counts in limp-home
   assign sw_on = gate_on & ENABLE_UV_IN & ~(limp & SET_PIN_BELOW_STOP);

   // a start is honoured only with calibration enabled and the engine idle
   assign start_ok = wr_go & hit(AVS_ADDRESS, OFF_CUR_CAL) & AVS_BYTEENABLE[0]
      & AVS_WRITEDATA[CAL_START_BIT] & cur.cal_enable & ~cal.busy;
   assign cal.start = start_ok;

   // interrupt sources
   always_comb begin
      events = '0;
      events[EV_CAL_DONE] = cal.done;
      events[EV_GATE_UV] = uv_block & ~cur.uv_prev;
      events[EV_LIMP] = limp & ~cur.limp_prev;
   end

   // sticky bits: a read clears only what it reported, so an event landing
   // between the capture edge and the answer edge waits for the next read
   for (genvar g = 0; g < NUM_EV; g++) begin : g_sticky
      assign irq_next[g] = events[g] | (cur.irq_status[g] & ~(clr_rd & cur.rdata[g]));
   end

   // read multiplexer, unmapped addresses read zero
   always_comb begin
      rd_val = 32'h0;
      if (hit(AVS_ADDRESS, OFF_ANALOG_DIM)) begin
         rd_val[7:0] = cur.dim_level;
      end else if (hit(AVS_ADDRESS, OFF_DEV_CTRL)) begin
         rd_val[CAL_EN_BIT] = cur.cal_enable;
      end else if (hit(AVS_ADDRESS, OFF_CUR_CAL)) begin
         rd_val[CAL_DONE_BIT] = cur.cal_done_flag;
         rd_val[CAL_BUSY_BIT] = cal.busy;
         rd_val[CAL_VAL_LSB +: 8] = cur.cal_applied;
      end else if (hit(AVS_ADDRESS, OFF_STATUS)) begin
         rd_val[ST_SWITCH_BIT] = cur.switch_en;
         rd_val[ST_GATE_BIT] = cur.gate_en;
         rd_val[ST_LIMP_BIT] = limp;
         rd_val[ST_MODE_LSB +: 2] = cur.mode_hold;
      end else if (hit(AVS_ADDRESS, OFF_IRQ_STATUS)) begin
         rd_val[NUM_EV-1:0] = cur.irq_status;
      end else if (hit(AVS_ADDRESS, OFF_IRQ_MASK)) begin
         rd_val[NUM_EV-1:0] = cur.irq_mask;
      end
   end

   // next state of the whole controller
   always_comb begin
      next_cur = cur;
      // one wait cycle, then the answer; ack drops so a held request restarts cleanly
      next_cur.ack = req & ~cur.ack;
      if (req & ~cur.ack) begin
         next_cur.rdata = AVS_READ ? rd_val : 32'h0;
         next_cur.resp = mapped(AVS_ADDRESS) ? RESP_OKAY : RESP_SLVERR;
      end
      // register writes
      if (wr_go) begin
         if (hit(AVS_ADDRESS, OFF_ANALOG_DIM) && AVS_BYTEENABLE[0]) begin
            next_cur.dim_level = AVS_WRITEDATA[7:0];
         end
         if (hit(AVS_ADDRESS, OFF_DEV_CTRL) && AVS_BYTEENABLE[0]) begin
            next_cur.cal_enable = AVS_WRITEDATA[CAL_EN_BIT];
         end
         if (hit(AVS_ADDRESS, OFF_CUR_CAL) && AVS_BYTEENABLE[1]) begin
            next_cur.sw_cal = AVS_WRITEDATA[CAL_VAL_LSB +: 8];
         end
         if (hit(AVS_ADDRESS, OFF_IRQ_MASK) && AVS_BYTEENABLE[0]) begin
            next_cur.irq_mask = AVS_WRITEDATA[NUM_EV-1:0];
         end
      end
      // done flag: cleared by a new run, set by the engine; set wins
      if (start_ok) begin
         next_cur.cal_done_flag = 1'b0;
      end
      if (cal.done) begin
         next_cur.cal_done_flag = 1'b1;
      end
      // sticky status, read clear worked out per bit above; set wins
      next_cur.irq_status = irq_next;
      next_cur.limp_prev = limp;
      next_cur.uv_prev = uv_block;
      // mode readback frozen while pwm is low
      if (PWM_DIM_IN) begin
         next_cur.mode_hold = REG_MODE_IN;
      end
      // dimming source: set pin only in limp-home, otherwise software level
      next_cur.dim_target = limp ? SET_PIN_LEVEL : cur.dim_level;
      // applied calibration follows the enable bit
      next_cur.cal_applied = cur.cal_enable ? cal.result : cur.sw_cal;
      next_cur.switch_en = sw_on;
      next_cur.gate_en = gate_on;
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         cur <= '{
            ack: 1'b0,
            rdata: 32'h0,
            resp: RESP_OKAY,
            dim_level: RST_DIM_LEVEL,
            cal_enable: 1'b0,
            sw_cal: RST_CAL_VALUE,
            cal_done_flag: 1'b0,
            irq_status: '0,
            irq_mask: RST_IRQ_MASK,
            mode_hold: RST_MODE,
            limp_prev: 1'b0,
            uv_prev: 1'b0,
            dim_target: RST_DIM_LEVEL,
            cal_applied: RST_CAL_VALUE,
            switch_en: 1'b0,
            gate_en: 1'b0
         };
      end else begin
         cur <= next_cur;
      end
   end

   // outputs
   assign AVS_WAITREQUEST = req & ~cur.ack;
   assign AVS_READDATA = cur.rdata;
   assign AVS_RESPONSE = cur.resp;
   assign DIM_TARGET = cur.dim_target;
   assign CAL_APPLIED = cur.cal_applied;
   assign SWITCH_EN = cur.switch_en;
   assign GATE_DRV_EN = cur.gate_en;
   assign IRQ = |(cur.irq_status & cur.irq_mask);
endmodule
`default_nettype wire

// ### bench/dimcal_properties.sv
// checker for the dimming, limp-home and gate control outputs
`default_nettype none
module dimcal_checker (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic AVS_WRITE,
   input wire logic PWM_DIM_IN,
   input wire logic LIMP_HOME_IN,
   input wire logic ENABLE_UV_IN,
   input wire logic GATE_SUPPLY_INT_UV,
   input wire logic GATE_SUPPLY_EXT_UV,
   input wire logic [7:0] SET_PIN_LEVEL,
   input wire logic SET_PIN_BELOW_STOP,
   input wire logic [7:0] DIM_TARGET,
   input wire logic SWITCH_EN,
   input wire logic GATE_DRV_EN
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] up;
   logic uvb;
   // internal reset trails the pin by two flops, so hold checks off until it has gone
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B)
         up <= 3'h0;
      else
         up <= {up[1:0], 1'b1};
   end
   assign uvb = GATE_SUPPLY_EXT_UV | (GATE_SUPPLY_INT_UV & ~LIMP_HOME_IN);
   default clocking @(posedge CLK); endclocking
   default disable iff (!up[2]);
   // two quiet cycles: no limp-home and no register write
   sequence s_quiet;
      (!LIMP_HOME_IN && !AVS_WRITE) [*2];
   endsequence
   property p_no_switch; !(PWM_DIM_IN && ENABLE_UV_IN) |=> !SWITCH_EN; endproperty
   property p_switch_on;
      PWM_DIM_IN && ENABLE_UV_IN && !uvb && !(LIMP_HOME_IN && SET_PIN_BELOW_STOP) |=> SWITCH_EN;
   endproperty
   property p_stop; LIMP_HOME_IN && SET_PIN_BELOW_STOP |=> !SWITCH_EN; endproperty
   property p_gate_on; PWM_DIM_IN && !uvb |=> GATE_DRV_EN; endproperty
   property p_gate_off; !PWM_DIM_IN |=> !GATE_DRV_EN; endproperty
   property p_uv_ext; GATE_SUPPLY_EXT_UV |=> !GATE_DRV_EN && !SWITCH_EN; endproperty
   property p_limp_level; LIMP_HOME_IN |=> DIM_TARGET == $past(SET_PIN_LEVEL); endproperty
   property p_ignore_set; s_quiet |=> $stable(DIM_TARGET); endproperty
   a_no_switch: assert property (p_no_switch)
      else $error("switching without pwm and enable");
   a_switch_on: assert property (p_switch_on)
      else $error("switching not enabled");
   a_stop: assert property (p_stop)
      else $error("switching below stop level");
   a_gate_on: assert property (p_gate_on)
      else $error("gate drivers not enabled");
   a_gate_off: assert property (p_gate_off)
      else $error("gate drivers on with pwm low");
   a_uv_ext: assert property (p_uv_ext)
      else $error("gate drivers on under supply undervoltage");
   a_limp_level: assert property (p_limp_level)
      else $error("target not from level pin");
   a_ignore_set: assert property (p_ignore_set)
      else $error("target moved without a write");
endmodule
bind led_dimming_calibration_ctrl dimcal_checker u_chk (.CLK, .RST_B, .AVS_WRITE,
   .PWM_DIM_IN, .LIMP_HOME_IN, .ENABLE_UV_IN, .GATE_SUPPLY_INT_UV, .GATE_SUPPLY_EXT_UV,
   .SET_PIN_LEVEL, .SET_PIN_BELOW_STOP, .DIM_TARGET, .SWITCH_EN, .GATE_DRV_EN);
`default_nettype wire

// ### bench/avs_host.sv
// host controller model: avalon master reaching the control registers
`default_nettype none
module avs_host (
   input wire logic CLK,
   input wire logic waitreq,
   input wire logic [31:0] rdata,
   output logic [7:0] addr,
   output logic rd_en,
   output logic wr_en,
   output logic [31:0] wdata,
   output logic [31:0] q
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {addr, rd_en, wr_en, wdata, q} = '0;
   end
   // request held until an edge sees waitrequest low; data taken at that edge
   task automatic go(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      addr <= a;
      wdata <= d;
      wr_en <= w;
      rd_en <= !w;
      @(posedge CLK);
      while (waitreq !== 1'b0)
         @(posedge CLK);
      q = rdata;
      // released address and data lines show the inverse, never a stale value; strobes drop
      addr <= ~a;
      wdata <= ~d;
      wr_en <= 1'b0;
      rd_en <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      go(1'b0, a, 32'h0);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      go(1'b1, a, d);
   endtask
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// self-checking bench for the dimming and calibration controller
`default_nettype none
module tb_top;
   import dimcal_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned CYC = 20;
   logic clk, rst_b, pwm, limp, en, iuv, euv, stop, rd, wr, wreq, sw, gate, irq, ub;
   logic [7:0] lvl, meas, addr, tgt, appl;
   logic [1:0] mode, resp;
   logic [31:0] wdata, rdata, q;
   int fail_count, n_compared;
   // short routine keeps the calibration wait to about twenty cycles
   led_dimming_calibration_ctrl #(.CAL_CYCLES(CYC)) u_dut (.CLK(clk), .RST_B(rst_b),
      .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
      .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata), .AVS_RESPONSE(resp),
      .AVS_WAITREQUEST(wreq), .PWM_DIM_IN(pwm), .LIMP_HOME_IN(limp), .ENABLE_UV_IN(en),
      .GATE_SUPPLY_INT_UV(iuv), .GATE_SUPPLY_EXT_UV(euv), .SET_PIN_LEVEL(lvl),
      .SET_PIN_BELOW_STOP(stop), .REG_MODE_IN(mode), .CAL_OFFSET_MEAS(meas),
      .DIM_TARGET(tgt), .CAL_APPLIED(appl), .SWITCH_EN(sw), .GATE_DRV_EN(gate), .IRQ(irq));
   avs_host h (.CLK(clk), .waitreq(wreq), .rdata(rdata), .addr(addr), .rd_en(rd),
      .wr_en(wr), .wdata(wdata), .q(q));
   always #2 clk = ~clk;
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
         fail_count++;
      end
   endtask
   // registered outputs trail the pins by one edge
   task automatic settle;
      repeat (2) @(posedge clk);
   endtask
   task automatic conclude;
      $display("compared %0d mismatched %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (4000) @(posedge clk);
      fail_count++;
      conclude();
   end
   initial begin
      {clk, rst_b, pwm, limp, en, iuv, euv, stop, mode, lvl, meas} = '0;
      fail_count = 0;
      n_compared = 0;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      h.rd(OFF_ANALOG_DIM);
      chk("dim_level", 32'(RST_DIM_LEVEL), q);
      h.rd(8'h20);
      chk("response", 32'(RESP_SLVERR), 32'(resp));
      $display("end reset test");
      h.wr(OFF_ANALOG_DIM, 32'h5A);
      lvl <= 8'hC3;
      settle();
      chk("dim_target", 32'h5A, 32'(tgt));
      limp <= 1'b1;
      settle();
      chk("dim_target", 32'hC3, 32'(tgt));
      h.rd(OFF_STATUS);
      chk("limp", 32'h1, 32'(q[ST_LIMP_BIT]));
      $display("end dimming test");
      // every combination of the six one-bit control pins
      for (int i = 0; i < 64; i++) begin
         {limp, pwm, en, iuv, euv, stop} <= 6'(i);
         settle();
         ub = euv | (iuv & ~limp);
         chk("switch_en", 32'(pwm & en & ~ub & ~(limp & stop)), 32'(sw));
         chk("gate_drv_en", 32'(pwm & ~ub), 32'(gate));
      end
      $display("end switching test");
      {limp, pwm, en, iuv, euv, stop} <= 6'b011000;
      mode <= 2'h2;
      settle();
      pwm <= 1'b0;
      mode <= 2'h1;
      settle();
      h.rd(OFF_STATUS);
      chk("mode", 32'h2, 32'(q[ST_MODE_LSB +: 2]));
      $display("end mode test");
      h.wr(OFF_CUR_CAL, 32'h3C01);
      repeat (CYC + 5) @(posedge clk);
      h.rd(OFF_CUR_CAL);
      chk("cal reg", 32'h3C00, q);
      chk("cal applied", 32'h3C, 32'(appl));
      // pwm low and load off from here on
      meas <= 8'h27;
      h.rd(OFF_IRQ_STATUS);
      h.wr(OFF_DEV_CTRL, 32'h1);
      h.wr(OFF_CUR_CAL, 32'h1);
      h.rd(OFF_CUR_CAL);
      chk("cal busy", 32'h2, 32'(q[2:1]));
      for (int k = 0; k < 20 && q[CAL_DONE_BIT] !== 1'b1; k++)
         h.rd(OFF_CUR_CAL);
      chk("cal reg", 32'h2702, q);
      @(posedge clk);
      chk("cal applied", 32'h27, 32'(appl));
      chk("irq", 32'h0, 32'(irq));
      h.wr(OFF_IRQ_MASK, 32'h1);
      @(posedge clk);
      chk("irq", 32'h1, 32'(irq));
      h.rd(OFF_IRQ_STATUS);
      chk("irq status", 32'h1, q);
      @(posedge clk);
      chk("irq", 32'h0, 32'(irq));
      // periodic recalibration with pwm still low picks up the new offset
      meas <= 8'h31;
      h.wr(OFF_CUR_CAL, 32'h1);
      h.rd(OFF_CUR_CAL);
      chk("cal done", 32'h0, 32'(q[CAL_DONE_BIT]));
      for (int k = 0; k < 20 && q[CAL_DONE_BIT] !== 1'b1; k++)
         h.rd(OFF_CUR_CAL);
      chk("cal reg", 32'h3102, q);
      $display("end calibration test");
      conclude();
   end
endmodule
`default_nettype wire
